/* src/judge_pkg.sv */
// shared constants and types for the servo status output judge
package judge_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ERR_W = 32;
   localparam int SPD_W = 16;
   localparam int ADDR_W = 5;
   localparam int WIN_W = 19;
   localparam int SEL_W = 2;
   localparam int HOLD_W = 15;
   localparam int THR_W = 15;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] WIN_OFS = 5'h00;
   localparam logic [ADDR_W-1:0] SEL_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] HOLD_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] ZERO_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] MATCH_OFS = 5'h10;
   localparam logic [ADDR_W-1:0] TURN_OFS = 5'h14;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h18;

   // ----------------------------------------------------------------
   // reset values and setting limits
   // ----------------------------------------------------------------
   localparam logic [WIN_W-1:0] WIN_RST = 19'h0000A;
   localparam logic [WIN_W-1:0] WIN_MAX = 19'h40000;
   localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
   localparam logic [HOLD_W-1:0] HOLD_RST = 15'h0000;
   localparam logic [HOLD_W-1:0] HOLD_MAX = 15'h7530;
   localparam logic [THR_W-1:0] ZERO_RST = 15'h0032;
   localparam logic [THR_W-1:0] MATCH_RST = 15'h0032;
   localparam logic [THR_W-1:0] TURN_RST = 15'h03E8;
   localparam logic [THR_W-1:0] THR_MIN = 15'h000A;
   localparam logic [THR_W-1:0] THR_MAX = 15'h4E20;

   // ----------------------------------------------------------------
   // completion condition selector values
   // ----------------------------------------------------------------
   localparam logic [SEL_W-1:0] SEL_ERR_ONLY = 2'h0;
   localparam logic [SEL_W-1:0] SEL_NO_CMD = 2'h1;
   localparam logic [SEL_W-1:0] SEL_NO_CMD_ZERO = 2'h2;
   localparam logic [SEL_W-1:0] SEL_HOLD = 2'h3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {HOLD_IDLE, HOLD_RUN, HOLD_FOLLOW}
      hold_state_type;

   typedef struct packed {
      logic pos_cmd_active;
      logic signed [ERR_W-1:0] pos_err;
      logic signed [SPD_W-1:0] spd_cmd;
      logic signed [SPD_W-1:0] spd_act;
   } loop_in_type;

   // pos_done is bit 0, motor_turning_flag bit 3
   typedef struct packed {
      logic motor_turning_flag;
      logic speed_match_flag;
      logic zero_speed_flag;
      logic pos_done;
   } flags_type;

   typedef struct packed {
      logic [WIN_W-1:0] position_window_threshold;
      logic [SEL_W-1:0] completion_condition_select;
      logic [HOLD_W-1:0] completion_hold_time;
      logic [THR_W-1:0] zero_speed_threshold;
      logic [THR_W-1:0] speed_match_range;
      logic [THR_W-1:0] rotation_detect_threshold;
   } cfg_type;

endpackage

/* src/ms_hold_timer.sv */
// millisecond hold timer for the positioning completion hold
`timescale 1ns/1ns
module ms_hold_timer
   import judge_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // control
   input wire logic start_i,
   input wire logic [HOLD_W-1:0] hold_ms_i,
   // status
   output logic expired_o
);

   localparam int DIV_W = $clog2(MS_CYCLES_P);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES_P - 1);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [HOLD_W-1:0] left;
      logic run;
   } timer_state_type;

   timer_state_type s_q;
   timer_state_type s_d;

   if (MS_CYCLES_P < 2) begin : g_chk
      $error("ms_hold_timer needs at least two cycles per ms");
   end

   // ----------------------------------------------------------------
   // count down whole milliseconds
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (ce_i) begin
         if (start_i) begin
            s_d.div = '0;
            s_d.left = hold_ms_i;
            s_d.run = (hold_ms_i != '0);
         end else if (s_q.run) begin
            if (s_q.div == DIV_LAST) begin
               s_d.div = '0;
               s_d.left = s_q.left - 15'h0001;
               if (s_q.left == 15'h0001) begin
                  s_d.run = 1'b0;
               end
            end else begin
               s_d.div = s_q.div + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign expired_o = !s_q.run;

endmodule

/* src/servo_status_judge.sv */
// servo status output judge with avalon-mm setting registers
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module servo_status_judge
   import judge_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // control loop quantities
   input wire logic eval_tick_i,
   input wire loop_in_type loop_i,
   // status outputs
   output flags_type status_flags_o
);

   typedef struct packed {
      cfg_type cfg;
      flags_type flags;
      hold_state_type hold_st;
      logic wait_q;
      logic [31:0] rdata;
   } judge_state_type;

   judge_state_type s_q;
   judge_state_type s_d;

   logic [ERR_W-1:0] err_abs;
   logic [SPD_W-1:0] spd_abs;
   logic signed [SPD_W:0] spd_diff;
   logic [SPD_W:0] diff_abs;
   logic win_ok;
   logic zero_ok;
   logic match_ok;
   logic turn_ok;
   logic cmd_idle;
   logic hold_expired;
   logic start_hold;

   if (MS_CYCLES_P < 2) begin : g_chk
      $error("servo_status_judge needs at least two cycles per ms");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // writes outside the setting range clamp to the nearest limit
   function automatic logic [THR_W-1:0] clamp_thr(input logic [31:0] v);
      logic [THR_W-1:0] r;
      if (v < 32'(THR_MIN)) begin
         r = THR_MIN;
      end else if (v > 32'(THR_MAX)) begin
         r = THR_MAX;
      end else begin
         r = v[THR_W-1:0];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // magnitudes
   // ----------------------------------------------------------------
   // absolute value compare
   assign err_abs = loop_i.pos_err[ERR_W-1] ?
                    ERR_W'(-loop_i.pos_err) : ERR_W'(loop_i.pos_err);
   assign spd_abs = loop_i.spd_act[SPD_W-1] ?
                    SPD_W'(-loop_i.spd_act) : SPD_W'(loop_i.spd_act);
   assign spd_diff = {loop_i.spd_cmd[SPD_W-1], loop_i.spd_cmd}
                   - {loop_i.spd_act[SPD_W-1], loop_i.spd_act};
   assign diff_abs = spd_diff[SPD_W] ?
                     (SPD_W+1)'(-spd_diff) : (SPD_W+1)'(spd_diff);

   assign win_ok = err_abs <
      ERR_W'(s_q.cfg.position_window_threshold);
   assign zero_ok = spd_abs < SPD_W'(s_q.cfg.zero_speed_threshold);
   assign match_ok = diff_abs <= (SPD_W+1)'(s_q.cfg.speed_match_range);
   assign turn_ok = spd_abs >= SPD_W'(s_q.cfg.rotation_detect_threshold);
   assign cmd_idle = !loop_i.pos_cmd_active;

   // ----------------------------------------------------------------
   // hold timer
   // ----------------------------------------------------------------
   // 1 ms hold timebase
   ms_hold_timer #(
      .MS_CYCLES_P(MS_CYCLES_P)
   ) u_hold (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .start_i(start_hold),
      .hold_ms_i(s_q.cfg.completion_hold_time),
      .expired_o(hold_expired)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      start_hold = 1'b0;
      if (ce_i) begin
         // one wait cycle, then the answer stands for one cycle
         if ((avs_read_i || avs_write_i) && s_q.wait_q) begin
            s_d.wait_q = 1'b0;
            s_d.rdata = '0;
            if (avs_read_i) begin
               if (avs_address_i == WIN_OFS) begin
                  s_d.rdata = 32'(s_q.cfg.position_window_threshold);
               end else if (avs_address_i == SEL_OFS) begin
                  s_d.rdata = 32'(s_q.cfg.completion_condition_select);
               end else if (avs_address_i == HOLD_OFS) begin
                  s_d.rdata = 32'(s_q.cfg.completion_hold_time);
               end else if (avs_address_i == ZERO_OFS) begin
                  s_d.rdata = 32'(s_q.cfg.zero_speed_threshold);
               end else if (avs_address_i == MATCH_OFS) begin
                  s_d.rdata = 32'(s_q.cfg.speed_match_range);
               end else if (avs_address_i == TURN_OFS) begin
                  s_d.rdata = 32'(s_q.cfg.rotation_detect_threshold);
               end else if (avs_address_i == STATUS_OFS) begin
                  s_d.rdata = {26'h0000000, s_q.hold_st, s_q.flags};
               end
            end
         end else if ((avs_read_i || avs_write_i) && !s_q.wait_q) begin
            s_d.wait_q = 1'b1;
            if (avs_write_i) begin
               if (avs_address_i == WIN_OFS) begin
                  if (merge_bytes(32'(s_q.cfg.position_window_threshold),
                        avs_writedata_i, avs_byteenable_i) >
                        32'(WIN_MAX)) begin
                     s_d.cfg.position_window_threshold = WIN_MAX;
                  end else begin
                     s_d.cfg.position_window_threshold = WIN_W'(
                        merge_bytes(
                        32'(s_q.cfg.position_window_threshold),
                        avs_writedata_i, avs_byteenable_i));
                  end
               end else if (avs_address_i == SEL_OFS) begin
                  if (avs_byteenable_i[0]) begin
                     s_d.cfg.completion_condition_select =
                        avs_writedata_i[SEL_W-1:0];
                  end
               end else if (avs_address_i == HOLD_OFS) begin
                  if (merge_bytes(32'(s_q.cfg.completion_hold_time),
                        avs_writedata_i, avs_byteenable_i) >
                        32'(HOLD_MAX)) begin
                     s_d.cfg.completion_hold_time = HOLD_MAX;
                  end else begin
                     s_d.cfg.completion_hold_time = HOLD_W'(
                        merge_bytes(32'(s_q.cfg.completion_hold_time),
                        avs_writedata_i, avs_byteenable_i));
                  end
               end else if (avs_address_i == ZERO_OFS) begin
                  s_d.cfg.zero_speed_threshold = clamp_thr(merge_bytes(
                     32'(s_q.cfg.zero_speed_threshold),
                     avs_writedata_i, avs_byteenable_i));
               end else if (avs_address_i == MATCH_OFS) begin
                  s_d.cfg.speed_match_range = clamp_thr(merge_bytes(
                     32'(s_q.cfg.speed_match_range),
                     avs_writedata_i, avs_byteenable_i));
               end else if (avs_address_i == TURN_OFS) begin
                  s_d.cfg.rotation_detect_threshold =
                     clamp_thr(merge_bytes(
                     32'(s_q.cfg.rotation_detect_threshold),
                     avs_writedata_i, avs_byteenable_i));
               end
            end
         end else begin
            s_d.wait_q = 1'b1;
         end

         if (eval_tick_i) begin
            s_d.flags.zero_speed_flag = zero_ok;
            s_d.flags.speed_match_flag = match_ok;
            s_d.flags.motor_turning_flag = turn_ok;
            s_d.hold_st = HOLD_IDLE;
            case (s_q.cfg.completion_condition_select)
               SEL_ERR_ONLY: begin
                  s_d.flags.pos_done = win_ok;
               end
               SEL_NO_CMD: begin
                  s_d.flags.pos_done = cmd_idle && win_ok;
               end
               SEL_NO_CMD_ZERO: begin
                  // plus zero speed, judged this cycle
                  s_d.flags.pos_done = cmd_idle && zero_ok && win_ok;
               end
               default: begin
                  // hold on, then follow the error
                  case (s_q.hold_st)
                     HOLD_IDLE: begin
                        s_d.flags.pos_done = cmd_idle && win_ok;
                        if (cmd_idle && win_ok) begin
                           start_hold = 1'b1;
                           s_d.hold_st = HOLD_RUN;
                        end
                     end
                     HOLD_RUN: begin
                        s_d.hold_st = HOLD_RUN;
                        s_d.flags.pos_done = 1'b1;
                        if (hold_expired) begin
                           s_d.hold_st = HOLD_FOLLOW;
                           s_d.flags.pos_done = win_ok;
                        end
                     end
                     HOLD_FOLLOW: begin
                        // a new command restarts the qualification
                        if (cmd_idle) begin
                           s_d.hold_st = HOLD_FOLLOW;
                           s_d.flags.pos_done = win_ok;
                        end else begin
                           s_d.flags.pos_done = 1'b0;
                        end
                     end
                     default: begin
                        s_d.flags.pos_done = 1'b0;
                     end
                  endcase
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q.cfg.position_window_threshold <= WIN_RST;
         s_q.cfg.completion_condition_select <= SEL_RST;
         s_q.cfg.completion_hold_time <= HOLD_RST;
         s_q.cfg.zero_speed_threshold <= ZERO_RST;
         s_q.cfg.speed_match_range <= MATCH_RST;
         s_q.cfg.rotation_detect_threshold <= TURN_RST;
         s_q.flags <= '0;
         s_q.hold_st <= HOLD_IDLE;
         s_q.wait_q <= 1'b1;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata_o = s_q.rdata;
   assign avs_waitrequest_o = s_q.wait_q;
   assign status_flags_o = s_q.flags;

endmodule

/* bench/servo_status_judge_assertions.sv */
// concurrent checks on the servo status judge ports
`timescale 1ns/1ns
module servo_status_judge_assertions
   import judge_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // judge
   input wire logic eval_tick_i,
   input wire loop_in_type loop_i,
   input wire flags_type status_flags_o
);
   // ---------------------------------------------------------------
   // bus and judge checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic take;
   logic tick;
   assign take = (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
   assign tick = eval_tick_i && ce_i;

   a_wait_one: assert property (take |=> !avs_waitrequest_o)
      else $error("no answer one cycle after a request");
   a_wait_stands: assert property (!avs_waitrequest_o && ce_i |=>
      avs_waitrequest_o) else $error("answer held longer than one cycle");
   a_wait_idle: assert property (!(avs_read_i || avs_write_i) &&
      avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
      else $error("answer without a request");
   a_upper_zero: assert property (!avs_waitrequest_o |->
      avs_readdata_o[31:19] == 13'h0000) else $error("upper read bits set");
   a_unmapped_read: assert property (take && avs_read_i &&
      avs_address_i[4:2] == 3'h7 |=> avs_readdata_o == 32'h00000000)
      else $error("unmapped read not zero");
   a_status_read: assert property (take && avs_read_i && !eval_tick_i &&
      avs_address_i == STATUS_OFS |=> avs_readdata_o[3:0] == status_flags_o)
      else $error("status read differs from flags");
   a_reset_clear: assert property ($rose(arst_n_i) |->
      status_flags_o == 4'h0 && avs_waitrequest_o)
      else $error("outputs not cleared by reset");
   a_flags_hold: assert property (!tick |=> $stable(status_flags_o))
      else $error("flags changed without a tick");
   a_match_equal: assert property (tick &&
      loop_i.spd_cmd == loop_i.spd_act |=> status_flags_o.speed_match_flag)
      else $error("equal speeds not judged matching");
   a_stopped_flags: assert property (tick &&
      loop_i.spd_act == 16'h0000 |=> status_flags_o.zero_speed_flag &&
      !status_flags_o.motor_turning_flag) else $error("stopped motor flags");
   a_fast_flags: assert property (tick &&
      (loop_i.spd_act >= 16'sh4E20 || loop_i.spd_act <= -16'sh4E20) |=>
      status_flags_o.motor_turning_flag && !status_flags_o.zero_speed_flag)
      else $error("fast motor flags");

   c_write: cover property (avs_write_i && !avs_waitrequest_o);
   c_done_rise: cover property ($rose(status_flags_o.pos_done));
   c_status: cover property (take && avs_read_i &&
      avs_address_i == STATUS_OFS);
endmodule

/* bench/host_status_model.sv */
// host status model: paces control-cycle ticks and latches the flags
`timescale 1ns/1ns
module host_status_model
   import judge_pkg::*;
#(
   parameter int TICK_PERIOD_P = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // drive side
   input wire flags_type status_flags_i,
   output logic eval_tick_o,
   // bench side
   output flags_type seen_o,
   output logic [15:0] captures_o
);
   logic [7:0] count_q;
   logic taken_q;
   // ---------------------------------------------------------------
   // control cycle pacing; flags read one cycle after each tick
   // ---------------------------------------------------------------
   assign eval_tick_o = (count_q == 8'(TICK_PERIOD_P - 1));
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_q <= 8'h00;
         taken_q <= 1'b0;
         seen_o <= 4'h0;
         captures_o <= 16'h0000;
      end else begin
         count_q <= eval_tick_o ? 8'h00 : count_q + 8'h01;
         taken_q <= eval_tick_o;
         if (taken_q) begin
            seen_o <= status_flags_i;
            captures_o <= captures_o + 16'h0001;
         end
      end
   end
endmodule

/* bench/testbench.sv */
// self-checking testbench for the servo status judge
`timescale 1ns/1ns
module testbench
   import judge_pkg::*;
;
   localparam int MS_P = 4;
   localparam int LIMIT = 4000;
   logic clk;
   logic arst_n;
   logic [ADDR_W-1:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [3:0] lanes = 4'hF;
   logic ce;
   logic [31:0] rdata;
   logic waitreq;
   logic tick;
   loop_in_type loop;
   flags_type flags;
   flags_type seen;
   logic [15:0] captures;
   logic [31:0] d;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [ADDR_W-1:0] cl_a [4] = '{WIN_OFS, HOLD_OFS, ZERO_OFS, TURN_OFS};
   logic [31:0] cl_w [4] = '{32'h00050000, 32'h00009C40, 32'h00000005,
      32'h000061A8};
   logic [31:0] cl_e [4] = '{32'(WIN_MAX), 32'(HOLD_MAX), 32'(THR_MIN),
      32'(THR_MAX)};
   logic [31:0] dflt [6] = '{32'(WIN_RST), 32'(SEL_RST), 32'(HOLD_RST),
      32'(ZERO_RST), 32'(MATCH_RST), 32'(TURN_RST)};

   servo_status_judge #(.MS_CYCLES_P(MS_P)) servo_status_judge_inst (
      .clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .eval_tick_i(tick), .loop_i(loop),
      .status_flags_o(flags));
   host_status_model host_status_model_inst (.clk_i(clk), .arst_n_i(arst_n),
      .status_flags_i(flags), .eval_tick_o(tick), .seen_o(seen),
      .captures_o(captures));

   // ---------------------------------------------------------------
   // clock, timeout and reporting
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_flags(input flags_type got, input flags_type exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t flags %h expected %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is seen low, then one idle cycle
   task automatic bus(input logic w, input int a, input logic [31:0] v);
      rd <= !w;
      wr <= w;
      addr <= ADDR_W'(a);
      wdata <= v;
      be <= lanes;
      @(posedge clk);
      while (waitreq) @(posedge clk);
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_ticks(input int n);
      logic [15:0] c;
      repeat (n) begin
         c = captures;
         while (captures == c) @(posedge clk);
      end
   endtask
   // second capture is the first whose tick surely saw the new loop values
   task automatic judge(input logic c, input int e, input int sc, input int sa,
      input flags_type exp);
      loop <= '{c, 32'(e), 16'(sc), 16'(sa)};
      wait_ticks(2);
      check_flags(seen, exp);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h00;
      wdata = 32'h00000000;
      be = 4'h0;
      ce = 1'b1;
      loop = '0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 4 * i, 32'h0);
         check_word(d, dflt[i]);
      end
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, cl_a[i], cl_w[i]);
         bus(1'b0, cl_a[i], 32'h0);
         check_word(d, cl_e[i]);
      end
      bus(1'b1, 'h1C, 32'h00000055);
      bus(1'b0, 'h1C, 32'h0);
      check_word(d, 32'h00000000);
      // byte lanes: selector needs lane 0, others merge into the old word
      lanes = 4'h2;
      bus(1'b1, SEL_OFS, 32'h00000003);
      bus(1'b1, ZERO_OFS, 32'h00000100);
      lanes = 4'hF;
      bus(1'b0, SEL_OFS, 32'h0);
      check_word(d, 32'(SEL_RST));
      bus(1'b0, ZERO_OFS, 32'h0);
      check_word(d, 32'h0000010A);
      $display("test registers finished");
      for (int i = 0; i < 6; i++) bus(1'b1, 4 * i, dflt[i]);
      bus(1'b1, HOLD_OFS, 32'h00000008);
      judge(1'b1, 9, 0, 0, 4'h7);
      judge(1'b1, 10, 0, 0, 4'h6);
      judge(1'b1, -9, 0, 0, 4'h7);
      judge(1'b0, 100, 0, 49, 4'h6);
      judge(1'b0, 100, 0, -50, 4'h4);
      judge(1'b0, 100, 100, 49, 4'h2);
      judge(1'b0, 100, 0, -1000, 4'h8);
      judge(1'b0, 100, -999, -999, 4'h4);
      judge(1'b0, 100, -20000, -20000, 4'hC);
      $display("test mode0 and speeds finished");
      bus(1'b1, SEL_OFS, 32'(SEL_NO_CMD));
      judge(1'b1, 0, 0, 0, 4'h6);
      judge(1'b0, 0, 0, 0, 4'h7);
      bus(1'b1, SEL_OFS, 32'(SEL_NO_CMD_ZERO));
      judge(1'b0, 0, 100, 100, 4'h4);
      judge(1'b0, 0, -40, -40, 4'h7);
      $display("test modes 1 and 2 finished");
      bus(1'b1, SEL_OFS, 32'(SEL_HOLD));
      judge(1'b0, 0, 0, 0, 4'h7);
      judge(1'b1, 100, 0, 0, 4'h7);
      bus(1'b0, STATUS_OFS, 32'h0);
      check_word(d, 32'h00000017);
      wait_ticks(10);
      judge(1'b1, 100, 0, 0, 4'h6);
      judge(1'b0, 0, 0, 0, 4'h7);
      wait_ticks(10);
      judge(1'b0, 100, 0, 0, 4'h6);
      bus(1'b0, STATUS_OFS, 32'h0);
      check_word(d, 32'h00000026);
      bus(1'b1, ZERO_OFS, 32'h000000C8);
      judge(1'b1, 100, 0, 150, 4'h2);
      // enable low: ticks are ignored and the flags stay frozen
      ce <= 1'b0;
      judge(1'b0, 0, 0, 0, 4'h2);
      ce <= 1'b1;
      $display("test hold and update finished");
      end_sim();
   end
endmodule

bind servo_status_judge servo_status_judge_assertions #(
   .MS_CYCLES_P(MS_CYCLES_P)
) servo_status_judge_assertions_inst (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .eval_tick_i(eval_tick_i),
   .loop_i(loop_i), .status_flags_o(status_flags_o));
